// [fpr_pkg.sv]
// Package: register map, field layout, reset values and timing constants of the flow rate processor
package fpr_pkg;

	// ---------------------------------------------------------------
	// Register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_VMIN   = 8'h08;
	localparam logic [7:0] OFS_ACCCLS = 8'h0C;
	localparam logic [7:0] OFS_FILTER = 8'h10;
	localparam logic [7:0] OFS_COMPF  = 8'h14;
	localparam logic [7:0] OFS_RATE   = 8'h18;
	localparam logic [7:0] OFS_TOTAL  = 8'h1C;
	localparam logic [7:0] OFS_FREQ   = 8'h20;
	localparam logic [7:0] OFS_TABLE  = 8'h40;

	// ---------------------------------------------------------------
	// Field values and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  FLOW_SINGLE   = 2'h0;
	localparam logic [1:0]  FLOW_QUAD     = 2'h1;
	localparam logic [1:0]  FLOW_ANALOG   = 2'h2;
	localparam int          NPOINTS       = 10;
	localparam logic [15:0] TBL_SCALE_RST = 16'h0001;
	localparam logic [6:0]  FILTER_RST    = 7'h01;
	localparam logic [31:0] COMPF_RST     = 32'h0001_0000;
	localparam logic [7:0]  ERR_MISSING   = 8'h0D;
	localparam logic [7:0]  ERR_SIMUL     = 8'h12;
	localparam logic [11:0] TIMEBASE_MIN  = 12'h03C;
	localparam logic [11:0] TIMEBASE_HOUR = 12'hE10;
	localparam int          RATE_FRAC     = 8;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ       = 100_000_000;
	localparam int GATE_MS      = 250;
	localparam int GATES_PER_S  = 1000 / GATE_MS;
	localparam int GATE_CYC     = CLK_HZ / 1000 * GATE_MS;
	localparam int FLASH_MS     = 500;
	localparam int FLASH_CYC    = CLK_HZ / 1000 * FLASH_MS;

	// Temperature compensation methods
	typedef enum logic [1:0] {
		COMP_THERMAL = 2'b00,
		COMP_PETROL  = 2'b01,
		COMP_LPG     = 2'b10,
		COMP_AMMONIA = 2'b11
	} fpr_comp_type;

	// Control register layout
	typedef struct packed {
		logic         comp_en;
		fpr_comp_type comp_method;
		logic         per_hour;
		logic         nlin_en;
		logic         pulse_check_enable;
		logic [1:0]   flow_input_type;
	} fpr_ctrl_type;

endpackage

// [fpr_core.sv]
// Flow pulse rate processor: quadrature check, alarm, rate, linearisation, filter, APB registers
//
// Functional notes
// [R1] Pulse check only in quadrature mode, when enabled
// [R2] Hold minimum check volume and accuracy class
// [R3] Latch alarm on missing or simultaneous pulse
// [R4] Alarm: output low, relays off, stop lamp
// [R5] Keep counting pulses during alarm
// [R6] Flash code 13 missing, 18 simultaneous
// [R7] Stop key clears the latched error
// [R8] Rate is frequency times timebase over scale
// [R9] Scale factor is pulses per unit volume
// [R10] Compensation scales rate to base temperature
// [R11] No linearisation for analogue flow input
// [R12] Table of ten frequency and scale pairs
// [R13] Interpolate scale between neighbouring points
// [R14] First scale used above first frequency
// [R15] Zero frequency point ends the table
// [R16] Tenth frequency forced to zero
// [R17] Operator gives scale for the end point
// [R18] Filter constant one passes input unchanged
// [R19] Step settling matches tabulated filter times
// [R20] Selectable compensation method, base temperature; comp_method is only stored, the one compf_r factor applies to every method
// [R21] Stop key returns alarm output high
// [R22] Two pulses on one channel means missing
// [R23] Recursive average, one part in constant
module fpr_core #(
	parameter int GATE_CYCLES  = fpr_pkg::GATE_CYC,
	parameter int FLASH_CYCLES = fpr_pkg::FLASH_CYC
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RESET,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic        CH_A,
	input  wire logic        CH_B,
	input  wire logic        STOP_KEY,
	input  wire logic        RELAY1_REQ,
	input  wire logic        RELAY2_REQ,
	output logic             ALARM_N,
	output logic             RELAY1,
	output logic             RELAY2,
	output logic             STOP_LED,
	output logic      [7:0]  ERR_CODE
);

	initial
	begin
		if (GATE_CYCLES < 2 || FLASH_CYCLES < 2)
			$error("fpr_core: gate and flash periods need at least two cycles");
	end

	// ---------------------------------------------------------------
	// Pin synchronisers and debounce
	// ---------------------------------------------------------------
	logic [2:0] sa_r, sb_r, sk_r;
	logic       lvl_a_r, lvl_b_r, lvl_k_r;
	logic       edge_a, edge_b, edge_k;

	// Three stages; a level is accepted once stages two and three agree
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			sa_r    <= 3'h0;
			sb_r    <= 3'h0;
			sk_r    <= 3'h0;
			lvl_a_r <= 1'b0;
			lvl_b_r <= 1'b0;
			lvl_k_r <= 1'b0;
		end
		else
		begin
			sa_r <= {sa_r[1:0], CH_A};
			sb_r <= {sb_r[1:0], CH_B};
			sk_r <= {sk_r[1:0], STOP_KEY};
			if (sa_r[1] == sa_r[2])
				lvl_a_r <= sa_r[2];
			if (sb_r[1] == sb_r[2])
				lvl_b_r <= sb_r[2];
			if (sk_r[1] == sk_r[2])
				lvl_k_r <= sk_r[2];
		end
	end

	assign edge_a = (sa_r[1] == sa_r[2]) && sa_r[2] && !lvl_a_r;
	assign edge_b = (sb_r[1] == sb_r[2]) && sb_r[2] && !lvl_b_r;
	assign edge_k = (sk_r[1] == sk_r[2]) && sk_r[2] && !lvl_k_r;

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	fpr_pkg::fpr_ctrl_type ctrl_r;
	logic [31:0]           vmin_r;
	logic [15:0]           acccls_r;
	logic [6:0]            filt_a_r;
	logic [31:0]           compf_r;
	logic [15:0]           tbl_freq_r  [fpr_pkg::NPOINTS];
	logic [15:0]           tbl_scale_r [fpr_pkg::NPOINTS];
	logic                  wr_en;
	logic [5:0]            widx;
	logic                  check_on;

	assign wr_en = PSEL && PENABLE && PWRITE && PREADY;
	assign widx  = PADDR[7:2];
	assign check_on = ctrl_r.pulse_check_enable && (ctrl_r.flow_input_type == fpr_pkg::FLOW_QUAD); // [R1]

	// Software writes to the control and parameter words
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			ctrl_r   <= '0;
			vmin_r   <= 32'h0000_0000;
			acccls_r <= 16'h0000;
			filt_a_r <= fpr_pkg::FILTER_RST;
			compf_r  <= fpr_pkg::COMPF_RST;
		end
		else if (wr_en)
		begin
			case (PADDR)
				fpr_pkg::OFS_CTRL:
				begin
					ctrl_r <= PWDATA[7:0];
					// Analogue input cannot be linearised
					if (PWDATA[1:0] == fpr_pkg::FLOW_ANALOG)
						ctrl_r.nlin_en <= 1'b0; // [R11]
				end
				fpr_pkg::OFS_VMIN:   vmin_r   <= PWDATA; // [R2]
				fpr_pkg::OFS_ACCCLS: acccls_r <= PWDATA[15:0]; // [R2]
				fpr_pkg::OFS_FILTER: filt_a_r <= (PWDATA[6:0] == 7'h00) ? 7'h01 : PWDATA[6:0];
				fpr_pkg::OFS_COMPF:  compf_r  <= PWDATA;
				default: ;
			endcase
		end
	end

	// Correction table; last frequency slot always reads zero
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			for (int i = 0; i < fpr_pkg::NPOINTS; i++)
			begin
				tbl_freq_r[i]  <= 16'h0000;
				tbl_scale_r[i] <= fpr_pkg::TBL_SCALE_RST;
			end
		end
		else if (wr_en && PADDR >= fpr_pkg::OFS_TABLE)
		begin
			for (int i = 0; i < fpr_pkg::NPOINTS; i++)
			begin
				if (widx == 6'(fpr_pkg::OFS_TABLE[7:2] + i)) // [R12]
				begin
					tbl_freq_r[i]  <= (i == fpr_pkg::NPOINTS - 1) ? 16'h0000 : PWDATA[15:0]; // [R16]
					tbl_scale_r[i] <= PWDATA[31:16]; // [R17]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Quadrature check and alarm
	// ---------------------------------------------------------------
	logic miss_r, sim_r, last_b_r, last_ok_r;
	logic miss_set, sim_set, miss_nxt, sim_nxt, alarm_nxt;
	logic [31:0] total_r;

	// One channel twice in a row means the other dropped a pulse
	assign sim_set  = check_on && edge_a && edge_b; // [R3]
	assign miss_set = check_on && last_ok_r && !sim_set
		&& ((edge_a && !edge_b && !last_b_r) || (edge_b && !edge_a && last_b_r)); // [R22]
	// A new error in the clearing cycle survives the stop key
	assign miss_nxt  = miss_set || (miss_r && !edge_k); // [R7]
	assign sim_nxt   = sim_set || (sim_r && !edge_k); // [R7]
	assign alarm_nxt = miss_nxt || sim_nxt;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			miss_r    <= 1'b0;
			sim_r     <= 1'b0;
			last_b_r  <= 1'b0;
			last_ok_r <= 1'b0;
		end
		else
		begin
			miss_r <= miss_nxt; // [R3]
			sim_r  <= sim_nxt; // [R3]
			if (edge_a != edge_b)
			begin
				last_b_r  <= edge_b;
				last_ok_r <= 1'b1;
			end
			else if (edge_a)
				last_ok_r <= 1'b0;
		end
	end

	// Totals keep running whatever the alarm state
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
			total_r <= 32'h0000_0000;
		else if (edge_a)
			total_r <= total_r + 32'h0000_0001; // [R5]
	end

	// Alarm outputs follow the next alarm state so they leave flip-flops
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			ALARM_N  <= 1'b1;
			RELAY1   <= 1'b0;
			RELAY2   <= 1'b0;
			STOP_LED <= 1'b0;
		end
		else
		begin
			ALARM_N  <= !alarm_nxt; // [R4] [R21]
			RELAY1   <= RELAY1_REQ && !alarm_nxt; // [R4]
			RELAY2   <= RELAY2_REQ && !alarm_nxt; // [R4]
			STOP_LED <= alarm_nxt; // [R4]
		end
	end

	// Display flash: code shows during every other flash period
	logic [31:0] flash_cnt_r;
	logic        flash_on_r;

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			flash_cnt_r <= 32'h0000_0000;
			flash_on_r  <= 1'b0;
			ERR_CODE    <= 8'h00;
		end
		else
		begin
			if (flash_cnt_r == 32'(FLASH_CYCLES - 1))
			begin
				flash_cnt_r <= 32'h0000_0000;
				flash_on_r  <= !flash_on_r;
			end
			else
				flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
			if (miss_r && flash_on_r)
				ERR_CODE <= fpr_pkg::ERR_MISSING; // [R6]
			else if (sim_r && flash_on_r)
				ERR_CODE <= fpr_pkg::ERR_SIMUL; // [R6]
			else
				ERR_CODE <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Frequency gate
	// ---------------------------------------------------------------
	logic [31:0] gate_cnt_r;
	logic [13:0] pcnt_r;
	logic [15:0] freq_r;
	logic        gate_tick_r;

	// Filter settling is paced by this gate period
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			gate_cnt_r  <= 32'h0000_0000;
			pcnt_r      <= 14'h0000;
			freq_r      <= 16'h0000;
			gate_tick_r <= 1'b0;
		end
		else
		begin
			gate_tick_r <= 1'b0;
			if (gate_cnt_r == 32'(GATE_CYCLES - 1))
			begin
				gate_cnt_r  <= 32'h0000_0000;
				freq_r      <= 16'(pcnt_r * fpr_pkg::GATES_PER_S);
				pcnt_r      <= {13'h0000, edge_a};
				gate_tick_r <= 1'b1;
			end
			else
			begin
				gate_cnt_r <= gate_cnt_r + 32'h0000_0001;
				if (edge_a && pcnt_r != 14'h3FFF)
					pcnt_r <= pcnt_r + 14'h0001;
			end
		end
	end

	// ---------------------------------------------------------------
	// Segment search over the correction table
	// ---------------------------------------------------------------
	logic       seg_found;
	logic [3:0] seg_idx;
	logic       seg_alive;

	always_comb
	begin
		seg_found = 1'b0;
		seg_idx   = 4'h0;
		seg_alive = 1'b1;
		for (int i = 0; i < fpr_pkg::NPOINTS - 1; i++)
		begin
			if (tbl_freq_r[i] == 16'h0000)
				seg_alive = 1'b0; // [R15]
			if (seg_alive && !seg_found && freq_r < tbl_freq_r[i] && freq_r >= tbl_freq_r[i + 1])
			begin
				seg_found = 1'b1;
				seg_idx   = 4'(i);
			end
		end
	end

	// ---------------------------------------------------------------
	// Shared shift-subtract divider
	// ---------------------------------------------------------------
	logic [47:0] div_q_r;
	logic [32:0] div_rem_r;
	logic [31:0] div_den_r;
	logic [5:0]  div_cnt_r;
	logic        div_busy_r, div_done_r, div_go;
	logic [47:0] div_num;
	logic [31:0] div_den;
	logic [32:0] div_t;

	assign div_t = {div_rem_r[31:0], div_q_r[47]};

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			div_q_r    <= 48'h0;
			div_rem_r  <= 33'h0;
			div_den_r  <= 32'h0;
			div_cnt_r  <= 6'h00;
			div_busy_r <= 1'b0;
			div_done_r <= 1'b0;
		end
		else
		begin
			div_done_r <= 1'b0;
			if (div_go)
			begin
				div_q_r    <= div_num;
				div_rem_r  <= 33'h0;
				div_den_r  <= div_den;
				div_cnt_r  <= 6'h00;
				div_busy_r <= 1'b1;
			end
			else if (div_busy_r)
			begin
				if (div_t >= {1'b0, div_den_r})
				begin
					div_rem_r <= div_t - {1'b0, div_den_r};
					div_q_r   <= {div_q_r[46:0], 1'b1};
				end
				else
				begin
					div_rem_r <= div_t;
					div_q_r   <= {div_q_r[46:0], 1'b0};
				end
				div_cnt_r <= div_cnt_r + 6'h01;
				if (div_cnt_r == 6'h2F)
				begin
					div_busy_r <= 1'b0;
					div_done_r <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Rate pipeline
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_INTERP = 3'b001,
		ST_RATE   = 3'b010,
		ST_FILT   = 3'b011
	} fpr_state_type;

	fpr_state_type st_r;
	logic          launched_r;
	logic [15:0]   scale_r;
	logic [31:0]   rate_raw_r, rate_f_r;
	logic [15:0]   s_hi, s_lo, f_hi, f_lo, ds;
	logic          ds_neg, up;
	logic [31:0]   rate_c;
	logic [63:0]   comp_prod;

	assign s_hi   = tbl_scale_r[seg_idx];
	assign s_lo   = tbl_scale_r[4'(seg_idx + 4'h1)];
	assign f_hi   = tbl_freq_r[seg_idx];
	assign f_lo   = tbl_freq_r[4'(seg_idx + 4'h1)];
	assign ds_neg = s_hi < s_lo;
	assign ds     = ds_neg ? s_lo - s_hi : s_hi - s_lo;
	// Compensation factor is unsigned Q16; one means no correction
	assign comp_prod = rate_raw_r * compf_r;
	assign rate_c    = ctrl_r.comp_en ? comp_prod[47:16] : rate_raw_r; // [R10] [R20]
	assign up        = rate_c >= rate_f_r;

	// Divider operands for each stage
	always_comb
	begin
		div_go  = 1'b0;
		div_num = 48'h0;
		div_den = 32'h1;
		if (!launched_r)
		begin
			case (st_r)
				ST_INTERP:
				begin
					div_go  = 1'b1;
					div_num = {16'h0, 32'(ds) * 32'(freq_r - f_lo)}; // [R13]
					div_den = {16'h0, f_hi - f_lo};
				end
				ST_RATE:
				begin
					div_go  = 1'b1;
					div_num = {4'h0, 36'(freq_r) * (ctrl_r.per_hour ? fpr_pkg::TIMEBASE_HOUR
						: fpr_pkg::TIMEBASE_MIN), 8'h00}; // [R8]
					div_den = {16'h0, scale_r}; // [R9]
				end
				ST_FILT:
				begin
					div_go  = 1'b1;
					div_num = {16'h0, up ? rate_c - rate_f_r : rate_f_r - rate_c}; // [R23]
					div_den = {25'h0, filt_a_r}; // [R18] [R19]
				end
				default: ;
			endcase
		end
	end

	// Sequencer: one pass per gate period
	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			st_r       <= ST_IDLE;
			launched_r <= 1'b0;
			scale_r    <= fpr_pkg::TBL_SCALE_RST;
			rate_raw_r <= 32'h0;
			rate_f_r   <= 32'h0;
		end
		else
		begin
			if (div_go)
				launched_r <= 1'b1;
			case (st_r)
				ST_IDLE:
				begin
					if (gate_tick_r)
					begin
						scale_r <= tbl_scale_r[0]; // [R14]
						if (ctrl_r.nlin_en && seg_found)
							st_r <= ST_INTERP;
						else
							st_r <= ST_RATE;
					end
				end
				ST_INTERP:
				begin
					if (div_done_r)
					begin
						scale_r    <= ds_neg ? s_lo - div_q_r[15:0] : s_lo + div_q_r[15:0]; // [R13]
						launched_r <= 1'b0;
						st_r       <= ST_RATE;
					end
				end
				ST_RATE:
				begin
					if (div_done_r)
					begin
						// A zero scale gives a zero rate rather than a bogus maximum
						rate_raw_r <= (scale_r == 16'h0) ? 32'h0 : div_q_r[31:0]; // [R8]
						launched_r <= 1'b0;
						st_r       <= ST_FILT;
					end
				end
				ST_FILT:
				begin
					if (div_done_r)
					begin
						rate_f_r   <= up ? rate_f_r + div_q_r[31:0] : rate_f_r - div_q_r[31:0]; // [R23]
						launched_r <= 1'b0;
						st_r       <= ST_IDLE;
					end
				end
				default:
				begin
					st_r       <= ST_IDLE;
					launched_r <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// APB slave: one wait state, registered answer
	// ---------------------------------------------------------------
	logic [31:0] rd_data;
	logic        rd_err;

	always_comb
	begin
		rd_data = 32'h0;
		rd_err  = 1'b0;
		case (PADDR)
			fpr_pkg::OFS_CTRL:   rd_data = {24'h0, ctrl_r};
			fpr_pkg::OFS_STATUS: rd_data = {16'h0, ERR_CODE, 5'h0, sim_r, miss_r, miss_r || sim_r};
			fpr_pkg::OFS_VMIN:   rd_data = vmin_r;
			fpr_pkg::OFS_ACCCLS: rd_data = {16'h0, acccls_r};
			fpr_pkg::OFS_FILTER: rd_data = {25'h0, filt_a_r};
			fpr_pkg::OFS_COMPF:  rd_data = compf_r;
			fpr_pkg::OFS_RATE:   rd_data = rate_f_r;
			fpr_pkg::OFS_TOTAL:  rd_data = total_r;
			fpr_pkg::OFS_FREQ:   rd_data = {16'h0, freq_r};
			default:
			begin
				rd_err = 1'b1;
				for (int i = 0; i < fpr_pkg::NPOINTS; i++)
				begin
					if (PADDR == 8'(fpr_pkg::OFS_TABLE + 4 * i))
					begin
						rd_data = {tbl_scale_r[i], tbl_freq_r[i]};
						rd_err  = 1'b0;
					end
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (RESET)
		begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY  <= PSEL && PENABLE && !PREADY;
			PRDATA  <= (PSEL && PENABLE && !PREADY && !PWRITE) ? rd_data : 32'h0;
			PSLVERR <= PSEL && PENABLE && !PREADY && rd_err;
		end
	end

endmodule

// [fpr_monitor.sv]
// Checker: port-level assertions of the flow rate processor, bound to its core
module fpr_monitor #(
	parameter int GATE_CYCLES  = fpr_pkg::GATE_CYC,
	parameter int FLASH_CYCLES = fpr_pkg::FLASH_CYC
) (
	input wire logic        CORE_CLK,
	input wire logic        RESET,
	input wire logic        PSEL,
	input wire logic        PENABLE,
	input wire logic        PWRITE,
	input wire logic [7:0]  PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic        PREADY,
	input wire logic        PSLVERR,
	input wire logic        CH_A,
	input wire logic        CH_B,
	input wire logic        STOP_KEY,
	input wire logic        RELAY1_REQ,
	input wire logic        RELAY2_REQ,
	input wire logic        ALARM_N,
	input wire logic        RELAY1,
	input wire logic        RELAY2,
	input wire logic        STOP_LED,
	input wire logic [7:0]  ERR_CODE
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] pin_hist_r;
	logic [7:0] key_hist_r;

	// Recent pin activity; the synchroniser delays any effect by a few cycles
	always_ff @(posedge CORE_CLK)
	begin
		pin_hist_r <= {pin_hist_r[6:0], CH_A | CH_B};
		key_hist_r <= {key_hist_r[6:0], STOP_KEY};
	end

	default clocking dc @(posedge CORE_CLK); endclocking
	default disable iff (RESET);

	// ----------------
	// Alarm outputs
	// ----------------
	a_relay_drop: assert property (!ALARM_N && !$past(ALARM_N) |-> !RELAY1 && !RELAY2)
		else $error("relay energised during alarm");
	a_relay_follow: assert property (ALARM_N && $past(ALARM_N) && !$past(RESET)
		|-> RELAY1 == $past(RELAY1_REQ) && RELAY2 == $past(RELAY2_REQ))
		else $error("relay does not follow its request");
	a_led_alarm: assert property (STOP_LED != ALARM_N)
		else $error("stop lamp disagrees with alarm");
	a_alarm_cause: assert property ($fell(ALARM_N) |-> |pin_hist_r)
		else $error("alarm raised without a pulse");
	a_alarm_clear: assert property ($rose(ALARM_N) |-> |key_hist_r)
		else $error("alarm cleared without stop key");
	a_code_legal: assert property (ERR_CODE != 8'h00 |-> (!ALARM_N || !$past(ALARM_N))
		&& (ERR_CODE == fpr_pkg::ERR_MISSING || ERR_CODE == fpr_pkg::ERR_SIMUL))
		else $error("bad error code");
	// Bound sized for the shortened flash period used in simulation
	a_code_shown: assert property ($fell(ALARM_N) |-> ##[1:40] (ERR_CODE != 8'h00 || ALARM_N))
		else $error("error code never flashed");

	// ----------------
	// Register bus
	// ----------------
	a_ready_wait: assert property ((PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
		else $error("ready not after one wait state");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	a_slverr_ready: assert property (PSLVERR |-> PREADY)
		else $error("error response without ready");
	a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
		else $error("read data not zero when idle");

	c_missing: cover property (ERR_CODE == fpr_pkg::ERR_MISSING);
	c_simul: cover property (ERR_CODE == fpr_pkg::ERR_SIMUL);
	c_cleared: cover property ($rose(ALARM_N));
	c_slverr: cover property (PSLVERR);
endmodule

bind fpr_core fpr_monitor #(.GATE_CYCLES(GATE_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) fpr_monitor_inst (
	.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
	.CH_A, .CH_B, .STOP_KEY, .RELAY1_REQ, .RELAY2_REQ, .ALARM_N, .RELAY1, .RELAY2, .STOP_LED, .ERR_CODE
);

// [fpr_sensor.sv]
// Partner model: two flowmeter pulse channels and the operator stop key
module fpr_sensor (
	input  wire logic clk,
	output logic      ch_a,
	output logic      ch_b,
	output logic      stop_key
);
	timeunit 1ns;
	timeprecision 1ps;

	bit run = 1'h0;

	// Pins idle low between pulses
	initial
	begin
		ch_a = 1'h0;
		ch_b = 1'h0;
		stop_key = 1'h0;
	end

	// One pulse; both levels last over three cycles so the synchroniser keeps them
	task automatic pulse(input logic a, input logic b, input int gap);
		@(posedge clk);
		ch_a <= a;
		ch_b <= b;
		repeat (4) @(posedge clk);
		ch_a <= 1'h0;
		ch_b <= 1'h0;
		repeat (gap) @(posedge clk);
	endtask

	// Steady channel A, one pulse every ten cycles, until run drops
	task automatic stream();
		while (run)
			pulse(1'h1, 1'h0, 5);
	endtask

	// Operator acknowledge of a pulse error
	task automatic press();
		@(posedge clk);
		stop_key <= 1'h1;
		repeat (8) @(posedge clk);
		stop_key <= 1'h0;
		repeat (8) @(posedge clk);
	endtask
endmodule

// [tb.sv]
// Testbench: self-checking bench of the flow rate processor
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int GATE = 400;
	localparam int FREQ = GATE / 10 * fpr_pkg::GATES_PER_S;

	logic        CORE_CLK   = 1'h0;
	logic        RESET      = 1'h1;
	logic        PSEL       = 1'h0;
	logic        PENABLE    = 1'h0;
	logic        PWRITE     = 1'h0;
	logic [7:0]  PADDR      = 8'h00;
	logic [31:0] PWDATA     = 32'h0;
	logic        RELAY1_REQ = 1'h0;
	logic        RELAY2_REQ = 1'h0;
	logic [31:0] PRDATA;
	logic        PREADY, PSLVERR, CH_A, CH_B, STOP_KEY, ALARM_N, RELAY1, RELAY2, STOP_LED;
	logic [7:0]  ERR_CODE;
	logic [31:0] q, t0, d;
	logic        e;
	int          miscompares = 0;
	int          comparisons = 0;
	int          seed        = 39836;
	int          n;

	fpr_core #(.GATE_CYCLES(GATE), .FLASH_CYCLES(8)) fpr_core_inst (
		.CORE_CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR,
		.CH_A, .CH_B, .STOP_KEY, .RELAY1_REQ, .RELAY2_REQ, .ALARM_N, .RELAY1, .RELAY2, .STOP_LED, .ERR_CODE
	);
	fpr_sensor fpr_sensor_inst (.clk(CORE_CLK), .ch_a(CH_A), .ch_b(CH_B), .stop_key(STOP_KEY));

	// 100 MHz core clock
	always #5 CORE_CLK = ~CORE_CLK;

	// ----------------
	// Helpers
	// ----------------
	task automatic end_of_test();
		if (miscompares == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; request held until ready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
		output logic err);
		int k;
		k = 0;
		PSEL <= 1'h1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= wd;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		do
		begin
			@(posedge CORE_CLK);
			k++;
		end
		while (PREADY !== 1'h1 && k < 16);
		if (PREADY !== 1'h1)
		begin
			miscompares++;
			end_of_test();
		end
		r = PRDATA;
		err = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
		@(posedge CORE_CLK);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] r;
		logic        err;
		apb(1'h1, a, wd, r, err);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic err;
		apb(1'h0, a, 32'h0, r, err);
	endtask

	// Flash period is short here, so a bounded wait sees the code
	task automatic waitcode(input logic [7:0] code);
		int k;
		k = 0;
		while (ERR_CODE !== code && k < 64)
		begin
			@(posedge CORE_CLK);
			k++;
		end
		chk(32'(ERR_CODE), 32'(code));
	endtask

	// Rate after several whole gates at the steady pulse stream
	task automatic rstep(input logic [31:0] ctrl, input logic [31:0] t0v, input logic [31:0] cf,
		output logic [31:0] r);
		wr(fpr_pkg::OFS_CTRL, ctrl);
		wr(fpr_pkg::OFS_TABLE, t0v);
		wr(fpr_pkg::OFS_COMPF, cf);
		repeat (4 * GATE) @(posedge CORE_CLK);
		rd(fpr_pkg::OFS_RATE, r);
	endtask

	// Expected rate in Q24.8: frequency times timebase over scale, then compensation
	function automatic logic [31:0] erate(input int f, input bit hr, input int s, input int cf);
		longint r;
		r = longint'(f) * (hr ? int'(fpr_pkg::TIMEBASE_HOUR) : int'(fpr_pkg::TIMEBASE_MIN)) * 256 / s;
		return 32'(r * cf / 65536);
	endfunction

	function automatic int iscale(input int f, input int f0, input int s0, input int f1, input int s1);
		return (f >= f0) ? s0 : s1 + (f - f1) * (s0 - s1) / (f0 - f1);
	endfunction

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge CORE_CLK);
		miscompares++;
		end_of_test();
	end

	// ----------------
	// Main sequence
	// ----------------
	initial
	begin
		repeat (3) @(posedge CORE_CLK);
		RESET <= 1'h0;
		@(posedge CORE_CLK);
		rd(fpr_pkg::OFS_FILTER, q);
		chk(q, 32'(fpr_pkg::FILTER_RST));
		rd(fpr_pkg::OFS_COMPF, q);
		chk(q, fpr_pkg::COMPF_RST);
		apb(1'h0, 8'h30, 32'h0, q, e);
		chk({q[30:0], e}, 32'h1);
		for (int i = 0; i < fpr_pkg::NPOINTS; i++)
		begin
			d = $random(seed);
			wr(fpr_pkg::OFS_TABLE + 8'(4 * i), d);
			rd(fpr_pkg::OFS_TABLE + 8'(4 * i), q);
			chk(q, (i == fpr_pkg::NPOINTS - 1) ? {d[31:16], 16'h0} : d);
		end
		for (int k = 0; k < 2; k++)
		begin
			d = 32'($random(seed)) & 32'h0000FFFF;
			wr(k ? fpr_pkg::OFS_ACCCLS : fpr_pkg::OFS_VMIN, d);
			rd(k ? fpr_pkg::OFS_ACCCLS : fpr_pkg::OFS_VMIN, q);
			chk(q, d);
		end
		wr(fpr_pkg::OFS_CTRL, 32'h0000000A);
		rd(fpr_pkg::OFS_CTRL, q);
		chk(q & 32'hFF, 32'h02);
		for (int m = 0; m < 4; m++)
		begin
			d = 32'h89 | 32'(m << 5);
			wr(fpr_pkg::OFS_CTRL, d);
			rd(fpr_pkg::OFS_CTRL, q);
			chk(q & 32'hFF, d);
		end
		wr(fpr_pkg::OFS_FILTER, 32'h0);
		rd(fpr_pkg::OFS_FILTER, q);
		chk(q & 32'h7F, 32'h1);
		wr(fpr_pkg::OFS_FILTER, 32'h1);

		// Pulse check: off unless quadrature and enabled
		RELAY1_REQ <= 1'h1;
		RELAY2_REQ <= 1'($random(seed));
		for (int k = 0; k < 2; k++)
		begin
			wr(fpr_pkg::OFS_CTRL, k ? 32'h01 : 32'h04);
			fpr_sensor_inst.pulse(1'h1, 1'h0, 5);
			fpr_sensor_inst.pulse(1'h1, 1'h0, 5);
			chk(32'(ALARM_N), 32'h1);
		end
		wr(fpr_pkg::OFS_CTRL, 32'h05);
		n = 2 + ($random(seed) & 3);
		repeat (n)
		begin
			fpr_sensor_inst.pulse(1'h0, 1'h1, 2 + ($random(seed) & 7));
			fpr_sensor_inst.pulse(1'h1, 1'h0, 2 + ($random(seed) & 7));
		end
		chk(32'(ALARM_N), 32'h1);
		fpr_sensor_inst.pulse(1'h1, 1'h0, 5);
		chk(32'({ALARM_N, STOP_LED, RELAY1, RELAY2}), 32'h4);
		rd(fpr_pkg::OFS_STATUS, q);
		chk(q & 32'h7, 32'h3);
		waitcode(fpr_pkg::ERR_MISSING);
		rd(fpr_pkg::OFS_TOTAL, t0);
		repeat (3)
		begin
			fpr_sensor_inst.pulse(1'h1, 1'h0, 5);
			fpr_sensor_inst.pulse(1'h0, 1'h1, 5);
		end
		rd(fpr_pkg::OFS_TOTAL, q);
		chk(q, t0 + 32'h3);
		fpr_sensor_inst.press();
		chk(32'({ALARM_N, STOP_LED, RELAY1, RELAY2}), 32'({3'h5, RELAY2_REQ}));
		fpr_sensor_inst.pulse(1'h1, 1'h1, 5);
		waitcode(fpr_pkg::ERR_SIMUL);
		rd(fpr_pkg::OFS_STATUS, q);
		chk(q & 32'h7, 32'h5);
		fpr_sensor_inst.press();
		rd(fpr_pkg::OFS_STATUS, q);
		chk(q & 32'h7, 32'h0);

		// Rate with a steady stream on channel A
		wr(fpr_pkg::OFS_TABLE + 8'h04, {16'h0020, 16'h0050});
		wr(fpr_pkg::OFS_TABLE + 8'h08, {16'h0030, 16'h0000});
		fpr_sensor_inst.run = 1'h1;
		fork
			fpr_sensor_inst.stream();
		join_none
		rstep(32'h00, {16'h0010, 16'h0064}, fpr_pkg::COMPF_RST, q);
		chk(q, erate(FREQ, 1'b0, 16, 65536));
		rd(fpr_pkg::OFS_FREQ, q);
		chk(q, 32'(FREQ));
		rstep(32'h10, {16'h0010, 16'h0064}, fpr_pkg::COMPF_RST, q);
		chk(q, erate(FREQ, 1'b1, 16, 65536));
		rstep(32'h80, {16'h0010, 16'h0064}, 32'h00008000, q);
		chk(q, erate(FREQ, 1'b0, 16, 32768));
		rstep(32'h08, {16'h0010, 16'h00F0}, fpr_pkg::COMPF_RST, q);
		chk(q, erate(FREQ, 1'b0, iscale(FREQ, 240, 16, 80, 32), 65536));
		rstep(32'h08, {16'h0010, 16'h0064}, fpr_pkg::COMPF_RST, q);
		chk(q, erate(FREQ, 1'b0, iscale(FREQ, 100, 16, 80, 32), 65536));
		wr(fpr_pkg::OFS_FILTER, 32'h2);
		wr(fpr_pkg::OFS_TABLE, {16'h0008, 16'h0064});
		repeat (GATE + 200) @(posedge CORE_CLK);
		rd(fpr_pkg::OFS_RATE, q);
		chk(32'(q > erate(FREQ, 1'b0, 16, 65536) && q < erate(FREQ, 1'b0, 8, 65536)), 32'h1);
		fpr_sensor_inst.run = 1'h0;
		end_of_test();
	end
endmodule
